// >>> src/rio_master_map.svh
// Constants for the remote I/O master error and indication block.
// Assumes a 20 MHz system clock; included by name from src/.
`ifndef RIO_MASTER_MAP_SVH
`define RIO_MASTER_MAP_SVH

`define CLK_HZ            20000000
// ------------------------------------------------------------
// Flash timing
// ------------------------------------------------------------
`define FLASH_HALF_MS     250
`define FLASH_HALF_CYC    ((`CLK_HZ / 1000) * `FLASH_HALF_MS)
// ------------------------------------------------------------
// Host error code and flag positions
// ------------------------------------------------------------
`define RIO_ERR_CODE      16'hb008
`define FLAG_ERR_BIT      0
`define FLAG_SUSP_BIT     1
// ------------------------------------------------------------
// Output reset values
// ------------------------------------------------------------
`define STATUS_IND_RST    1'b0
`define TERM_IND_RST      1'b1

`endif

// >>> src/rio_master_pkg.sv
// Types shared by the remote I/O master error block.
// Assumes nothing of its surroundings.
`default_nettype none
package rio_master_pkg;
  typedef enum logic [3:0] {
    ST_TERM_CHK = 4'h1,
    ST_RUN      = 4'h2,
    ST_DEGRADED = 4'h4,
    ST_STOPPED  = 4'h8
  } link_state_t;
endpackage : rio_master_pkg
`default_nettype wire

// >>> src/flash_gen.sv
// Free-running square wave used to flash the status indicator.
// Assumes one synchronous clock and a shared clock enable.
`default_nettype none
module flash_gen #(
  parameter int unsigned HALF_CYC = 5000000
) (
  input  wire logic i_clk,
  input  wire logic i_sys_rst,
  input  wire logic i_ce,
  output logic      o_wave
);
  logic [31:0] count;

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      count  <= 32'h0;
      o_wave <= 1'b0;
    end
    else if (i_ce)
    begin
      if (count >= HALF_CYC - 1)
      begin
        count  <= 32'h0;
        o_wave <= ~o_wave;
      end
      else
      begin
        count <= count + 32'h1;
      end
    end
  end
endmodule : flash_gen
`default_nettype wire

// >>> src/rio_master_error.sv
// Error mode and indication logic of a remote I/O line master.
// Assumes the poll engine reports line events as same-clock levels and pulses,
// and that mode, recovery and unit fault pins come from outside the clock domain.
`include "rio_master_map.svh"
`default_nettype none
module rio_master_error #(
  parameter int unsigned N_SLAVES = 8,
  parameter int unsigned HALF_CYC = `FLASH_HALF_CYC
) (
  input  wire logic                i_clk,
  input  wire logic                i_sys_rst,
  input  wire logic                i_ce,
  input  wire logic                i_stop_mode,
  input  wire logic                i_recover,
  input  wire logic [N_SLAVES-1:0] i_slave_fault,
  input  wire logic                i_term_ack,
  input  wire logic                i_line_fault,
  output logic [N_SLAVES-1:0]      o_slave_tx_en,
  output logic                     o_transmission_status_indicator,
  output logic                     o_terminator_check_indicator,
  output logic                     o_host_alarm,
  output logic [15:0]              o_host_err_code,
  output logic [1:0]               o_host_flags
);
  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  // Mode, recovery and fault pins are wired from outside this clock, so each
  // passes two flops before any logic reads it. Recovery acts on the rising
  // edge only; a pin that is already high when reset ends counts as a press.
  logic [N_SLAVES+1:0] sync_a;
  logic [N_SLAVES+1:0] sync_b;
  wire  logic [N_SLAVES-1:0] fault_s = sync_b[N_SLAVES-1:0];
  wire  logic                stop_s  = sync_b[N_SLAVES];
  wire  logic                rec_s   = sync_b[N_SLAVES+1];
  logic                      rec_d;
  wire  logic                rec_pulse = rec_s & ~rec_d;

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      sync_a <= '0;
      sync_b <= '0;
      rec_d  <= 1'b0;
    end
    else if (i_ce)
    begin
      sync_a <= {i_recover, i_stop_mode, i_slave_fault};
      sync_b <= sync_a;
      rec_d  <= rec_s;
    end
  end

  // ------------------------------------------------------------
  // Line state
  // ------------------------------------------------------------
  // The line starts in terminator check. Faults seen there light the status
  // indicator and clear a faulty slave's send enable, but until the terminator
  // answers the line is not known to work, so the host alarm waits.
  rio_master_pkg::link_state_t state;
  rio_master_pkg::link_state_t next_state;
  logic                        mode;
  logic                        alarm;
  logic                        next_alarm;

  // ------------------------------------------------------------
  // State decode
  // ------------------------------------------------------------
  // One decode of the state register, shared by the alarm, mode and output logic; the next-state case decodes it on its own.
  function automatic logic state_is(
    input rio_master_pkg::link_state_t cur,
    input rio_master_pkg::link_state_t want
  );
    return cur == want;
  endfunction : state_is

  // Only slave faults raise the alarm; a line fault from the poll engine
  // lights the indicator but names no slave for the host to report.
  wire logic any_fault = |fault_s;
  wire logic fault_now = any_fault | i_line_fault;
  wire logic term_chk  = state_is(state, rio_master_pkg::ST_TERM_CHK);
  wire logic stopped   = state_is(state, rio_master_pkg::ST_STOPPED);

  // Continue mode sits in the degraded state while any slave is down and
  // returns to run by itself; stop mode waits for a recovery press.
  always_comb
  begin
    next_state = state;
    case (state)
      rio_master_pkg::ST_TERM_CHK:
        if (i_term_ack)
          next_state = rio_master_pkg::ST_RUN;
      rio_master_pkg::ST_RUN:
        if (any_fault && mode)
          next_state = rio_master_pkg::ST_STOPPED;
        else if (any_fault)
          next_state = rio_master_pkg::ST_DEGRADED;
      rio_master_pkg::ST_DEGRADED:
        // resume on repair
        // Continue mode never suspends; each slave rejoins on its own.
        if (!any_fault)
          next_state = rio_master_pkg::ST_RUN;
      rio_master_pkg::ST_STOPPED:
        // explicit recovery
        // A recovery with a slave still down leaves the line stopped.
        if (rec_pulse && !any_fault)
          next_state = rio_master_pkg::ST_RUN;
      default:
        next_state = rio_master_pkg::ST_TERM_CHK;
    endcase
  end

  // alarm set wins
  // A fault still present re-arms the alarm in the very cycle of a recovery
  // press, so a recovery never hides a slave that is still down.
  assign next_alarm = (~term_chk & any_fault) | (alarm & ~rec_pulse);

  // State, alarm and mode share one register block so that a recovery press
  // acts on all three in the same cycle.
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      state <= rio_master_pkg::ST_TERM_CHK;
      alarm <= 1'b0;
      mode  <= 1'b0;
    end
    else if (i_ce)
    begin
      state <= next_state;
      alarm <= next_alarm;
      // master mode setting
      // The mode is taken only while the terminator is awaited or at a
      // recovery, so flipping the pin mid-run cannot release a stopped line.
      if (term_chk || rec_pulse)
        mode <= stop_s;
    end
  end

  // ------------------------------------------------------------
  // Indicators and host outputs
  // ------------------------------------------------------------
  // Every host-facing output is a flop, so the host never samples a value
  // while it settles through the decode below.
  logic                     wave;
  wire logic [N_SLAVES-1:0] next_tx_en;
  wire logic                next_status;
  wire logic                next_term_ind;
  wire logic [15:0]         next_err_code;
  wire logic [1:0]          next_flags;

  // The flash runs freely instead of restarting on each repair, so a unit
  // that recovers falls straight back into the common rhythm.
  flash_gen #(
    .HALF_CYC (HALF_CYC)
  ) u_flash (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_ce      (i_ce),
    .o_wave    (wave)
  );

  // In stop mode the indicator stays lit even after the slave returns.
  // A line fault lights it too, before and after the terminator answers.
  wire logic lit_err = stopped | fault_now;

  // healthy slaves continue
  // A slave that is down is skipped; all others keep their exchanges unless the line is stopped, which halts every slave.
  assign next_tx_en = stopped ? '0 : ~fault_s;
  assign next_status = lit_err ? 1'b1 : wave;
  assign next_term_ind = term_chk;
  assign next_err_code = alarm ? `RIO_ERR_CODE : 16'h0000;
  assign next_flags[`FLAG_ERR_BIT]  = alarm;
  assign next_flags[`FLAG_SUSP_BIT] = stopped;

  // After reset the terminator check indicator is on and the status
  // indicator dark, until the first flash edge or fault reaches it.
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      o_slave_tx_en                   <= '0;
      o_transmission_status_indicator <= `STATUS_IND_RST;
      o_terminator_check_indicator    <= `TERM_IND_RST;
      o_host_alarm                    <= 1'b0;
      o_host_err_code                 <= 16'h0000;
      o_host_flags                    <= 2'h0;
    end
    else if (i_ce)
    begin
      o_slave_tx_en                   <= next_tx_en;
      o_transmission_status_indicator <= next_status;
      o_terminator_check_indicator    <= next_term_ind;
      o_host_alarm                    <= alarm;
      o_host_err_code                 <= next_err_code;
      o_host_flags                    <= next_flags;
    end
  end
endmodule : rio_master_error
`default_nettype wire

// >>> dv/rio_master_error_checker.sv
// Assertions on the ports of the remote I/O master error block.
// Assumes i_ce stays high; bound into every instance of the block.
`include "rio_master_map.svh"
`default_nettype none
module rio_master_error_checker #(
  parameter int unsigned N_SLAVES = 8
) (
  input wire logic                i_clk,
  input wire logic                i_sys_rst,
  input wire logic                i_stop_mode,
  input wire logic                i_recover,
  input wire logic [N_SLAVES-1:0] i_slave_fault,
  input wire logic                i_term_ack,
  input wire logic [N_SLAVES-1:0] o_slave_tx_en,
  input wire logic                o_transmission_status_indicator,
  input wire logic                o_terminator_check_indicator,
  input wire logic                o_host_alarm,
  input wire logic [15:0]         o_host_err_code,
  input wire logic [1:0]          o_host_flags
);
  timeunit 1ns;
  timeprecision 1ns;
  // --------------------------------------------------------
  // Cycles since the last recovery request, saturating.
  // --------------------------------------------------------
  logic [3:0] since_rec;
  always_ff @(posedge i_clk)
    if (i_sys_rst || i_recover)
      since_rec <= 4'h0;
    else if (since_rec != 4'hf)
      since_rec <= since_rec + 4'h1;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  a_code_alarm:
    assert property (o_host_err_code == (o_host_alarm ? `RIO_ERR_CODE : 16'h0000))
    else $error("error code does not follow alarm");
  a_flag_alarm:
    assert property (o_host_flags[0] == o_host_alarm) else $error("error flag wrong");
  a_alarm_sticky:
    assert property ($fell(o_host_alarm) |-> since_rec < 4'h9)
    else $error("alarm cleared without recovery");
  a_stop_idle:
    assert property (o_host_flags[1] |-> o_slave_tx_en == '0) else $error("sends while stopped");
  a_term_clear:
    assert property (i_term_ack && o_terminator_check_indicator
      |-> ##2 !o_terminator_check_indicator) else $error("terminator not acknowledged");
  a_fault_alarm:
    assert property ($rose(|i_slave_fault) && !o_terminator_check_indicator
      |-> ##[1:6] o_host_alarm) else $error("no alarm on slave fault");
  a_cont_keep:
    assert property ($rose(i_slave_fault[0]) && !i_stop_mode && !o_terminator_check_indicator
      |-> ##6 (o_slave_tx_en[N_SLAVES-1:1] == '1 && o_transmission_status_indicator))
    else $error("continue mode dropped healthy slaves");
  a_stop_halt:
    assert property ($rose(|i_slave_fault) && i_stop_mode && !o_terminator_check_indicator
      |-> ##[1:6] o_host_flags == 2'b11) else $error("stop mode did not suspend");
  c_alarm: cover property ($rose(o_host_alarm));
  c_stop: cover property ($rose(o_host_flags[1]));
  c_term: cover property ($fell(o_terminator_check_indicator));
endmodule : rio_master_error_checker
bind rio_master_error rio_master_error_checker #(.N_SLAVES(N_SLAVES)) chk_u (
  .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_stop_mode(i_stop_mode), .i_recover(i_recover),
  .i_slave_fault(i_slave_fault), .i_term_ack(i_term_ack), .o_slave_tx_en(o_slave_tx_en),
  .o_transmission_status_indicator(o_transmission_status_indicator),
  .o_terminator_check_indicator(o_terminator_check_indicator), .o_host_alarm(o_host_alarm),
  .o_host_err_code(o_host_err_code), .o_host_flags(o_host_flags));
`default_nettype wire

// >>> dv/rio_slave_line.sv
// Model of the daisy-chained slaves behind the master.
// Assumes the master's clock; the bench switches slave power and the line.
`default_nettype none
module rio_slave_line (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_tx_en,
  input  wire logic [7:0] i_pwr_off,
  input  wire logic       i_line_ok,
  output logic [7:0]      o_fault,
  output logic            o_term_ack,
  output logic            o_line_fault,
  output var int          o_rx1
);
  timeunit 1ns;
  timeprecision 1ns;
  // An unpowered slave cuts the chain, so the terminator cannot answer.
  assign o_fault      = i_pwr_off;
  assign o_term_ack   = i_line_ok & ~|i_pwr_off;
  assign o_line_fault = ~i_line_ok;
  int rx_count = 0;
  assign o_rx1 = rx_count;
  always @(posedge i_clk)
    if (i_tx_en[1] && !i_pwr_off[1])
      rx_count <= rx_count + 1;
endmodule : rio_slave_line
`default_nettype wire

// >>> dv/rio_master_error_tb.sv
// Self-checking bench of the remote I/O master error block.
// Assumes the slave model and checker are compiled before it.
`include "rio_master_map.svh"
`default_nettype none
module rio_master_error_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        i_clk = 1'b0, i_sys_rst = 1'b1, stop = 1'b0, rec = 1'b0, ok = 1'b0;
  logic [7:0]  pwr = 8'h00, flt, tx;
  logic        ack, lf, st, ti, al;
  logic [15:0] code;
  logic [1:0]  fl;
  int          rx1, t, n, fail_count = 0, checked = 0;
  always #25 i_clk = ~i_clk;
  rio_master_error #(.N_SLAVES(8), .HALF_CYC(4)) dut_u (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_ce(1'b1), .i_stop_mode(stop), .i_recover(rec), .i_slave_fault(flt), .i_term_ack(ack),
    .i_line_fault(lf), .o_slave_tx_en(tx), .o_transmission_status_indicator(st),
    .o_terminator_check_indicator(ti), .o_host_alarm(al), .o_host_err_code(code),
    .o_host_flags(fl));
  rio_slave_line line_u (.i_clk(i_clk), .i_tx_en(tx), .i_pwr_off(pwr), .i_line_ok(ok),
    .o_fault(flt), .o_term_ack(ack), .o_line_fault(lf), .o_rx1(rx1));
  task automatic cyc(input int c);
    repeat (c) @(negedge i_clk);
  endtask : cyc
  task automatic chk(input logic good);
    checked++;
    if (good !== 1'b1)
    begin
      $display("ERROR %0t: unexpected output", $time);
      fail_count++;
    end
  endtask : chk
  task automatic results;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : results
  // Counts status changes; a 4 cycle half period gives about six in 24 cycles.
  task automatic toggles;
    logic last;
    last = st;
    t = 0;
    repeat (24)
    begin
      cyc(1);
      if (st !== last) t++;
      last = st;
    end
  endtask : toggles
  task automatic recover;
    rec = 1'b1;
    cyc(3);
    rec = 1'b0;
    cyc(8);
  endtask : recover
  task automatic t_term;
    chk(ti === 1'b1 && al === 1'b0 && fl === 2'b00 && tx === 8'h00 && code === 16'h0000);
    // The status indicator leaves its dark reset value at the first edge; skip that change.
    cyc(2);
    toggles();
    chk(t == 0 && st === 1'b1 && ti === 1'b1);
    ok = 1'b1;
    n = 0;
    while (ti !== 1'b0 && n < 10)
    begin
      cyc(1);
      n++;
    end
    chk(n < 10);
    if (n == 10) results();
    toggles();
    chk(t >= 4 && al === 1'b0);
  endtask : t_term
  task automatic t_cont;
    pwr = 8'h01;
    cyc(8);
    chk(al === 1'b1 && code === `RIO_ERR_CODE && fl === 2'b01);
    n = rx1;
    toggles();
    chk(t == 0 && st === 1'b1 && tx === 8'hfe && rx1 > n);
    pwr = 8'h00;
    cyc(8);
    toggles();
    chk(t >= 4 && al === 1'b1);
    stop = 1'b1;
    recover();
    chk(al === 1'b0 && code === 16'h0000 && fl === 2'b00);
  endtask : t_cont
  task automatic t_stop;
    pwr = 8'h01;
    cyc(8);
    chk(fl === 2'b11 && tx === 8'h00 && st === 1'b1);
    stop = 1'b0;
    pwr = 8'h00;
    n = rx1;
    cyc(20);
    chk(fl === 2'b11 && al === 1'b1 && tx === 8'h00);
    chk(st === 1'b1 && rx1 == n);
    recover();
    chk(fl === 2'b00 && tx === 8'hff);
  endtask : t_stop
  initial
  begin
    cyc(4);
    i_sys_rst = 1'b0;
    t_term();
    t_cont();
    t_stop();
    results();
  end
endmodule : rio_master_error_tb
`default_nettype wire
